/* core/tsi_chan.sv */
/*
 One channel of the transmit system interface: pin synchronisers, active edge
 detection of the transmit clock, rail capture and the indication output.
 Assumes configuration and condition inputs on clk, pins asynchronous.
*/
`timescale 1ns/10ps
`include "tsi_regs.svh"
module tsi_chan
(
   input wire logic clk,
   input wire logic rst_n,
   input wire tsi_pkg::tsi_fmt_t fmt,
   input wire logic [7:0] cfg,
   input wire logic [7:0] cond,
   input wire logic pin_pos,
   input wire logic pin_neg,
   input wire logic pin_clk,
   output logic mf_o,
   output logic mf_oe,
   output logic pos_o,
   output logic neg_o,
   output logic evt_o
);
   import tsi_pkg::*;

   logic [2:0] sp_q, sp_d, sn_q, sn_d, sc_q, sc_d;
   logic [2:0] lvl_q, lvl_d;
   logic clk_prev_q, clk_prev_d;
   logic pos_q, pos_d, neg_q, neg_d, mf_q, mf_d, oe_q, oe_d, evt_q, evt_d;
   logic pa, pb, pc, inv, act_edge, sel_cond;

   // Level counts only once the second and third stages agree
   always_comb begin
      sp_d = {sp_q[1:0], pin_pos};
      sn_d = {sn_q[1:0], pin_neg};
      sc_d = {sc_q[1:0], pin_clk};
      lvl_d = lvl_q;
      if (sp_q[1] == sp_q[2]) lvl_d[0] = sp_q[2];
      if (sn_q[1] == sn_q[2]) lvl_d[1] = sn_q[2];
      if (sc_q[1] == sc_q[2]) lvl_d[2] = sc_q[2];
      clk_prev_d = lvl_q[2];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sp_q <= 3'h0;
         sn_q <= 3'h0;
         sc_q <= 3'h0;
         lvl_q <= 3'h0;
         clk_prev_q <= 1'b0;
      end else begin
         sp_q <= sp_d;
         sn_q <= sn_d;
         sc_q <= sc_d;
         lvl_q <= lvl_d;
         clk_prev_q <= clk_prev_d;
      end
   end

   assign inv = cfg[`TSI_INV_BIT];
   assign pa = lvl_q[0] ^ inv;
   assign pb = lvl_q[1] ^ inv;
   assign pc = lvl_q[2] ^ inv;
   assign act_edge = cfg[`TSI_EDGE_BIT] ? (clk_prev_q & ~lvl_q[2]) : (~clk_prev_q & lvl_q[2]);
   assign sel_cond = cond[cfg[`TSI_SEL_MSB:`TSI_SEL_LSB]];

   always_comb begin
      pos_d = pos_q;
      neg_d = neg_q;
      mf_d = mf_q;
      oe_d = (fmt != TSI_FMT_DNRZ);
      case (fmt)
         TSI_FMT_SNRZ: begin
            if (act_edge) begin
               pos_d = pa;
               neg_d = 1'b0;
               mf_d = sel_cond;
            end
         end
         TSI_FMT_DNRZ: begin
            mf_d = 1'b0;
            if (act_edge) begin
               pos_d = pa & ~pb;
               neg_d = pb & ~pa;
            end
         end
         TSI_FMT_DRZ: begin
            pos_d = pa & ~pc;
            neg_d = pc & ~pa;
            mf_d = sel_cond;
         end
         default: begin
            pos_d = 1'b0;
            neg_d = 1'b0;
            mf_d = 1'b0;
         end
      endcase
      evt_d = mf_d & ~mf_q & oe_d;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pos_q <= 1'b0;
         neg_q <= 1'b0;
         mf_q <= 1'b0;
         oe_q <= 1'b0;
         evt_q <= 1'b0;
      end else begin
         pos_q <= pos_d;
         neg_q <= neg_d;
         mf_q <= mf_d;
         oe_q <= oe_d;
         evt_q <= evt_d;
      end
   end

   assign mf_o = mf_q;
   assign mf_oe = oe_q;
   assign pos_o = pos_q;
   assign neg_o = neg_q;
   assign evt_o = evt_q;

   dnrz_neg_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      (fmt == TSI_FMT_DNRZ && act_edge && pb && !pa) |=> neg_q && !pos_q) else $error("Negative rail not taken");
   pin_role_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      (fmt != TSI_FMT_DNRZ) |=> oe_q) else $error("Indication pin not driven");
   ind_select_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      (fmt == TSI_FMT_SNRZ && act_edge) |=> mf_q == $past(sel_cond)) else $error("Wrong indication source");
   dnrz_hold_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      (fmt == TSI_FMT_DNRZ && !act_edge) |=> $stable(pos_q) && $stable(neg_q)) else $error("Rails moved off edge");
   snrz_hold_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      (fmt == TSI_FMT_SNRZ && !act_edge) |=> $stable(mf_q) && $stable(pos_q)) else $error("Changed off edge");
   wrong_edge_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      (fmt == TSI_FMT_SNRZ && !cfg[`TSI_EDGE_BIT] && clk_prev_q && !lvl_q[2]) |=> $stable(pos_q))
      else $error("Captured on wrong edge");
   rz_neg_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      (fmt == TSI_FMT_DRZ && pc && !pa) |=> neg_q && !pos_q) else $error("RZ negative rail lost");
   snrz_data_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      (fmt == TSI_FMT_SNRZ && act_edge) |=> pos_q == $past(pa) && !neg_q) else $error("Single rail data wrong");
   rz_invert_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      (fmt == TSI_FMT_DRZ && inv && !lvl_q[0] && lvl_q[2]) |=> pos_q) else $error("Invert not applied");
   rz_space_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      (fmt == TSI_FMT_DRZ && pa == pc) |=> !pos_q && !neg_q) else $error("Space not produced");
endmodule

/* core/tsi_pkg.sv */
/*
 Types of the transmit system interface mux.
 Assumes nothing of its surroundings.
*/
package tsi_pkg;
   typedef enum logic [1:0] {
      TSI_FMT_SNRZ,
      TSI_FMT_DNRZ,
      TSI_FMT_DRZ
   } tsi_fmt_t;
endpackage

/* core/tsi_regs.svh */
/*
 Register offsets, field positions, reset values and timing counts of the
 transmit system interface mux. Assumes inclusion by bare name.
*/
`ifndef TSI_REGS_SVH
`define TSI_REGS_SVH

// Byte offsets on the register bus
`define TSI_CFG_BASE 8'h00
`define TSI_STATUS_OFF 8'h40
`define TSI_CLEAR_OFF 8'h44
`define TSI_ENABLE_OFF 8'h48
`define TSI_LINE_OFF 8'h4c

// Per-channel configuration fields
`define TSI_FMT_LSB 0
`define TSI_FMT_MSB 1
`define TSI_INV_BIT 3
`define TSI_EDGE_BIT 4
`define TSI_SEL_LSB 5
`define TSI_SEL_MSB 7
`define TSI_FMT_CODE_DNRZ 2'h1
`define TSI_FMT_CODE_DRZ 2'h2

// Reset values
`define TSI_CFG_RST 8'h00
`define TSI_ENABLE_RST 16'h0000

// Bus responses
`define TSI_RESP_OKAY 2'h0
`define TSI_RESP_SLVERR 2'h2

// Timing: system clock and transmit clocks in kHz, then counts in system clocks
`define TSI_CLK_KHZ 25000
`define TSI_LINK_E1_KHZ 2048
`define TSI_LINK_T1_KHZ 1544
`define TSI_E1_HALF_CYC (`TSI_CLK_KHZ / (2 * `TSI_LINK_E1_KHZ))
`define TSI_SYNC_CYC 3

`endif

/* core/tsi_top.sv */
/*
 Nine-channel transmit system interface mux with an AXI4-Lite register slave,
 sticky interrupt status and one level interrupt.
 Assumes AXI4-Lite masters on CLK; line pins come from other clock domains.
*/
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "tsi_regs.svh"
module tsi_top #(
   parameter int NUM_CH = 9
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic [7:0] AWADDR,
   input wire logic [2:0] AWPROT,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [7:0] ARADDR,
   input wire logic [2:0] ARPROT,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   output logic IRQ,
   input wire logic [NUM_CH-1:0] TX_POS_RAIL_IN,
   input wire logic [NUM_CH-1:0] TX_NEG_RAIL_IN,
   input wire logic [NUM_CH-1:0] TX_LINE_CLK_IN,
   output logic [NUM_CH-1:0] TX_MULTIFUNC_OUT,
   output logic [NUM_CH-1:0] TX_MULTIFUNC_OE,
   output logic [NUM_CH-1:0] LINE_TIP_POS,
   output logic [NUM_CH-1:0] LINE_TIP_NEG,
   input wire logic [NUM_CH-1:0] ARBITRARY_PATTERN,
   input wire logic [NUM_CH-1:0] SYS_ALARM_INDICATION,
   input wire logic [NUM_CH-1:0] TX_OVERCURRENT,
   input wire logic [NUM_CH-1:0] TX_LOSS_OF_SIGNAL,
   input wire logic [NUM_CH-1:0] SYS_EXCESS_ZEROS,
   input wire logic [NUM_CH-1:0] SYS_BIPOLAR_VIOLATION,
   input wire logic [NUM_CH-1:0] SYS_LOSS_OF_SIGNAL
);
   import tsi_pkg::*;

   // Configuration space holds sixteen words and the bitmaps sixteen bits
   if (NUM_CH < 1 || NUM_CH > 16) begin : g_bad_ch
      $error("NUM_CH must be 1..16");
   end
   // Sampling needs several system clocks per transmit clock half period
   if (`TSI_E1_HALF_CYC < `TSI_SYNC_CYC) begin : g_bad_clk
      $error("System clock too slow for the transmit clock");
   end

   logic [1:0] rst_sync_q;
   logic rst_n;

   // Async assert, two-flop release
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   function automatic logic [31:0] byte_mask(input logic [3:0] strb);
      byte_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction

   // Write channel state
   logic aw_full_q, aw_full_d, w_full_q, w_full_d;
   logic [7:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic wr_en, wr_hit;
   logic [5:0] wr_idx;

   assign wr_idx = awaddr_q[7:2];
   assign wr_hit = (wr_idx < 6'(NUM_CH)) || awaddr_q == `TSI_STATUS_OFF || awaddr_q == `TSI_CLEAR_OFF
      || awaddr_q == `TSI_ENABLE_OFF || awaddr_q == `TSI_LINE_OFF;

   always_comb begin
      aw_full_d = aw_full_q;
      awaddr_d = awaddr_q;
      w_full_d = w_full_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      wr_en = 1'b0;
      if (AWVALID && awready_q) begin
         aw_full_d = 1'b1;
         awaddr_d = AWADDR;
      end
      if (WVALID && wready_q) begin
         w_full_d = 1'b1;
         wdata_d = WDATA;
         wstrb_d = WSTRB;
      end
      if (bvalid_q && BREADY) begin
         bvalid_d = 1'b0;
      end
      // Address and data may arrive in either order
      if (aw_full_q && w_full_q && !bvalid_q) begin
         wr_en = 1'b1;
         aw_full_d = 1'b0;
         w_full_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = wr_hit ? `TSI_RESP_OKAY : `TSI_RESP_SLVERR;
      end
      awready_d = !aw_full_d && !bvalid_d;
      wready_d = !w_full_d && !bvalid_d;
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         aw_full_q <= 1'b0;
         awaddr_q <= 8'h00;
         w_full_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `TSI_RESP_OKAY;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
      end else begin
         aw_full_q <= aw_full_d;
         awaddr_q <= awaddr_d;
         w_full_q <= w_full_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
      end
   end

   assign AWREADY = awready_q;
   assign WREADY = wready_q;
   assign BVALID = bvalid_q;
   assign BRESP = bresp_q;

   // Register file and interrupt state
   logic [7:0] cfg_q [NUM_CH];
   logic [7:0] cfg_d [NUM_CH];
   logic [NUM_CH-1:0] status_q, status_d, enable_q, enable_d, clr_mask, evt;
   logic irq_q, irq_d;
   logic [31:0] wmask, wval;
   // Reset value is sixteen bits wide; the channels take their share of it
   localparam logic [15:0] enable_rst = `TSI_ENABLE_RST;

   assign wmask = byte_mask(wstrb_q);
   assign wval = wdata_q & wmask;

   always_comb begin
      cfg_d = cfg_q;
      enable_d = enable_q;
      clr_mask = '0;
      if (wr_en) begin
         if (wr_idx < 6'(NUM_CH)) begin
            cfg_d[wr_idx[3:0]] = (cfg_q[wr_idx[3:0]] & ~wmask[7:0]) | wval[7:0];
         end
         if (awaddr_q == `TSI_ENABLE_OFF) begin
            enable_d = (enable_q & ~wmask[NUM_CH-1:0]) | wval[NUM_CH-1:0];
         end
         if (awaddr_q == `TSI_CLEAR_OFF) begin
            clr_mask = wval[NUM_CH-1:0];
         end
      end
      // Set wins over a clear in the same cycle
      status_d = (status_q & ~clr_mask) | evt;
      irq_d = |(status_d & enable_d);
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_CH; i++) begin
            cfg_q[i] <= `TSI_CFG_RST;
         end
         enable_q <= enable_rst[NUM_CH-1:0];
         status_q <= '0;
         irq_q <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         enable_q <= enable_d;
         status_q <= status_d;
         irq_q <= irq_d;
      end
   end

   assign IRQ = irq_q;

   // Read channel
   logic arready_q, arready_d, rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic [5:0] rd_idx;

   assign rd_idx = ARADDR[7:2];

   always_comb begin
      arready_d = arready_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (rvalid_q && RREADY) begin
         rvalid_d = 1'b0;
         arready_d = 1'b1;
      end
      if (ARVALID && arready_q) begin
         arready_d = 1'b0;
         rvalid_d = 1'b1;
         rresp_d = `TSI_RESP_OKAY;
         rdata_d = 32'h0000_0000;
         if (rd_idx < 6'(NUM_CH)) begin
            rdata_d[7:0] = cfg_q[rd_idx[3:0]];
         end else if (ARADDR == `TSI_STATUS_OFF) begin
            rdata_d[NUM_CH-1:0] = status_q;
         end else if (ARADDR == `TSI_ENABLE_OFF) begin
            rdata_d[NUM_CH-1:0] = enable_q;
         end else if (ARADDR == `TSI_LINE_OFF) begin
            rdata_d[NUM_CH-1:0] = TX_MULTIFUNC_OUT;
            rdata_d[NUM_CH+15:16] = TX_MULTIFUNC_OE;
         end else if (ARADDR != `TSI_CLEAR_OFF) begin
            rresp_d = `TSI_RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `TSI_RESP_OKAY;
      end else begin
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   assign ARREADY = arready_q;
   assign RVALID = rvalid_q;
   assign RDATA = rdata_q;
   assign RRESP = rresp_q;

   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      tsi_fmt_t fmt;
      logic [7:0] cond;
      assign fmt = (cfg_q[c][`TSI_FMT_MSB:`TSI_FMT_LSB] == `TSI_FMT_CODE_DNRZ) ? TSI_FMT_DNRZ :
         (cfg_q[c][`TSI_FMT_MSB:`TSI_FMT_LSB] == `TSI_FMT_CODE_DRZ) ? TSI_FMT_DRZ : TSI_FMT_SNRZ;
      assign cond = {SYS_LOSS_OF_SIGNAL[c], SYS_EXCESS_ZEROS[c] | SYS_BIPOLAR_VIOLATION[c],
         SYS_BIPOLAR_VIOLATION[c], SYS_EXCESS_ZEROS[c], TX_LOSS_OF_SIGNAL[c], TX_OVERCURRENT[c],
         SYS_ALARM_INDICATION[c], ARBITRARY_PATTERN[c]};
      tsi_chan u_chan (
         .clk(CLK),
         .rst_n(rst_n),
         .fmt(fmt),
         .cfg(cfg_q[c]),
         .cond(cond),
         .pin_pos(TX_POS_RAIL_IN[c]),
         .pin_neg(TX_NEG_RAIL_IN[c]),
         .pin_clk(TX_LINE_CLK_IN[c]),
         .mf_o(TX_MULTIFUNC_OUT[c]),
         .mf_oe(TX_MULTIFUNC_OE[c]),
         .pos_o(LINE_TIP_POS[c]),
         .neg_o(LINE_TIP_NEG[c]),
         .evt_o(evt[c])
      );
   end

   status_sticky_a:
   assert property (@(posedge CLK) disable iff (!rst_n)
      (|(evt & ~status_q)) |=> (status_q & $past(evt)) == $past(evt)) else $error("Event lost in status");
   irq_level_a:
   assert property (@(posedge CLK) disable iff (!rst_n)
      ##1 IRQ == |(status_q & enable_q)) else $error("Interrupt level mismatch");
   read_latency_a:
   assert property (@(posedge CLK) disable iff (!rst_n)
      (ARVALID && ARREADY) |=> RVALID && !ARREADY) else $error("Read answer late");
   write_resp_a:
   assert property (@(posedge CLK) disable iff (!rst_n)
      (aw_full_q && w_full_q && !bvalid_q) |=> BVALID ##0 (BRESP == `TSI_RESP_OKAY) == $past(wr_hit))
      else $error("Write response wrong");
   aw_taken_a:
   assert property (@(posedge CLK) disable iff (!rst_n)
      (AWVALID && AWREADY) |=> !AWREADY) else $error("Write address taken twice");
   w_taken_a:
   assert property (@(posedge CLK) disable iff (!rst_n)
      (WVALID && WREADY) |=> !WREADY) else $error("Write data taken twice");
   bresp_hold_a:
   assert property (@(posedge CLK) disable iff (!rst_n)
      (BVALID && !BREADY) |=> BVALID && $stable(BRESP)) else $error("Write response dropped");
   rdata_hold_a:
   assert property (@(posedge CLK) disable iff (!rst_n)
      (RVALID && !RREADY) |=> RVALID && $stable(RDATA) && $stable(RRESP)) else $error("Read answer dropped");
   write_busy_a:
   assert property (@(posedge CLK) disable iff (!rst_n)
      BVALID |-> !AWREADY && !WREADY) else $error("Write accepted while response pending");
   read_busy_a:
   assert property (@(posedge CLK) disable iff (!rst_n)
      RVALID |-> !ARREADY) else $error("Read accepted while answer pending");
   enable_write_a:
   assert property (@(posedge CLK) disable iff (!rst_n)
      (wr_en && awaddr_q == `TSI_ENABLE_OFF && &wstrb_q[1:0]) |=> enable_q == $past(wdata_q[NUM_CH-1:0]))
      else $error("Enable write lost");
   clear_bit_a:
   assert property (@(posedge CLK) disable iff (!rst_n)
      (wr_en && awaddr_q == `TSI_CLEAR_OFF && wstrb_q[0] && wdata_q[0] && !evt[0]) |=> !status_q[0])
      else $error("Status clear ignored");
   status_keep_a:
   assert property (@(posedge CLK) disable iff (!rst_n)
      !(wr_en && awaddr_q == `TSI_CLEAR_OFF) |=> (status_q & $past(status_q)) == $past(status_q))
      else $error("Status bit fell without clear");

   rz_mode_c: cover property (@(posedge CLK) disable iff (!rst_n) g_ch[0].fmt == TSI_FMT_DRZ && LINE_TIP_NEG[0]);
   dnrz_mode_c: cover property (@(posedge CLK) disable iff (!rst_n) g_ch[0].fmt == TSI_FMT_DNRZ && LINE_TIP_POS[0]);
   irq_raise_c: cover property (@(posedge CLK) disable iff (!rst_n) $rose(IRQ));
   set_clear_c: cover property (@(posedge CLK) disable iff (!rst_n) |(evt & clr_mask));
   slverr_resp_c: cover property (@(posedge CLK) disable iff (!rst_n) BVALID && BREADY && BRESP == `TSI_RESP_SLVERR);
endmodule

/* verif/tsi_far_end.sv */
/*
 Behavioural framer in front of the nine transmit channels: link clock and rails.
 Assumes the bench sets mode, edge and rail values; the link clock runs only while run is high.
*/
`timescale 1ns/10ps
module tsi_far_end
(
   input wire logic run,
   input wire logic fall_act,
   input wire logic [1:0] mode,
   input wire logic [8:0] pos_v,
   input wire logic [8:0] neg_v,
   output logic [8:0] pos_o,
   output logic [8:0] neg_o,
   output logic [8:0] clk_o
);
   logic lclk = 1'b0;
   logic [8:0] pos_q = '0;
   logic [8:0] neg_q = '0;
   // 320 ns link clock, still when idle
   initial begin
      #7;
      forever begin
         #160;
         lclk = run ? ~lclk : 1'b0;
      end
   end
   // launch on the inactive edge so rails are stable at the active one
   always @(lclk) begin
      if (lclk == fall_act) begin
         pos_q = pos_v;
         neg_q = neg_v;
      end
   end
   // RZ negative rail on the clock pin; unused pin toggles so a stale level cannot pass
   assign pos_o = (mode == 2'h2) ? pos_v : pos_q;
   assign clk_o = (mode == 2'h2) ? neg_v : {9{lclk}};
   assign neg_o = (mode == 2'h1) ? neg_q : {9{lclk}};
endmodule

/* verif/tsi_top_tb_top.sv */
/*
 Self-checking bench of the transmit system interface mux: AXI4-Lite tasks and scenarios.
 Assumes the far-end model drives the line pins; condition inputs come from the bench.
*/
`timescale 1ns/10ps
`include "tsi_regs.svh"
module tsi_top_tb_top;
   logic CLK = 1'b0;
   logic RESETN = 1'b0;
   logic [7:0] awaddr = '0, araddr = '0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = '0, rd;
   logic [1:0] rs;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [8:0] pv = '0, nv = '0, pin_p, pin_n, pin_c, mf, oe, tp, tn;
   logic run = 0, fall = 0;
   logic [1:0] mode = '0;
   logic [6:0] cnd = '0;
   int bad_count = 0, comparisons = 0;
   always #20 CLK = ~CLK;

   tsi_far_end fe (.run(run), .fall_act(fall), .mode(mode), .pos_v(pv), .neg_v(nv), .pos_o(pin_p),
      .neg_o(pin_n), .clk_o(pin_c));
   tsi_top #(.NUM_CH(9)) uut (.CLK(CLK), .RESETN(RESETN), .AWADDR(awaddr), .AWPROT(3'h0),
      .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid),
      .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
      .ARPROT(3'h0), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
      .RVALID(rvalid), .RREADY(rready), .IRQ(irq), .TX_POS_RAIL_IN(pin_p), .TX_NEG_RAIL_IN(pin_n),
      .TX_LINE_CLK_IN(pin_c), .TX_MULTIFUNC_OUT(mf), .TX_MULTIFUNC_OE(oe), .LINE_TIP_POS(tp),
      .LINE_TIP_NEG(tn), .ARBITRARY_PATTERN({9{cnd[0]}}), .SYS_ALARM_INDICATION({9{cnd[1]}}),
      .TX_OVERCURRENT({9{cnd[2]}}), .TX_LOSS_OF_SIGNAL({9{cnd[3]}}), .SYS_EXCESS_ZEROS({9{cnd[4]}}),
      .SYS_BIPOLAR_VIOLATION({9{cnd[5]}}), .SYS_LOSS_OF_SIGNAL({9{cnd[6]}}));

   task end_sim;
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stuck();
      bad_count++;
      $display("ERROR bus handshake expected answer seen none");
      end_sim();
   endtask

   // Ready sampled at the falling edge equals its value at the next rising edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      logic ao, wo, bo;
      @(posedge CLK);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      for (n = 0; n < 100; n++) begin
         @(negedge CLK);
         ao = awvalid & awready;
         wo = wvalid & wready;
         bo = bready & bvalid;
         if (bo)
            r = bresp;
         @(posedge CLK);
         if (ao)
            awvalid <= 0;
         if (wo)
            wvalid <= 0;
         if (bo) begin
            bready <= 0;
            break;
         end
      end
      if (n == 100)
         stuck();
   endtask

   task automatic rdt(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic ao, ro;
      @(posedge CLK);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      for (n = 0; n < 100; n++) begin
         @(negedge CLK);
         ao = arvalid & arready;
         ro = rready & rvalid;
         if (ro) begin
            d = rdata;
            r = rresp;
         end
         @(posedge CLK);
         if (ao)
            arvalid <= 0;
         if (ro) begin
            rready <= 0;
            break;
         end
      end
      if (n == 100)
         stuck();
   endtask

   task automatic setall(input logic [7:0] c);
      for (int i = 0; i < 9; i++)
         wr(8'(4 * i), {24'h0, c}, rs);
   endtask

   // Five link periods cover sync, edge detection and output latency
   task automatic settle();
      repeat (40) @(posedge CLK);
   endtask

   function automatic logic sel_exp(input int k, input logic [6:0] c);
      return k < 6 ? c[k] : (k == 6 ? (c[4] | c[5]) : c[6]);
   endfunction

   initial begin
      repeat (2) @(posedge CLK);
      RESETN <= 1;
      repeat (4) @(posedge CLK);
      rdt(`TSI_CFG_BASE, rd, rs);
      chk("cfg0 reset", rd, 32'(`TSI_CFG_RST));
      rdt(`TSI_ENABLE_OFF, rd, rs);
      chk("enable reset", rd, 32'(`TSI_ENABLE_RST));
      rdt(8'h80, rd, rs);
      chk("unmapped read resp", 32'(rs), 32'(`TSI_RESP_SLVERR));
      wr(8'h80, 32'h1, rs);
      chk("unmapped write resp", 32'(rs), 32'(`TSI_RESP_SLVERR));
      // Single rail, rising edge; format code 3 falls back to single rail
      run <= 1;
      setall(8'h03);
      for (int v = 0; v < 2; v++) begin
         pv <= v ? 9'h0aa : 9'h155;
         settle();
         chk("single tip pos", 32'(tp), v ? 32'h0aa : 32'h155);
         chk("single tip neg", 32'(tn), 32'h0);
         chk("single oe", 32'(oe), 32'h1ff);
      end
      // Clock stood still: no capture
      run <= 0;
      settle();
      pv <= 9'h0f0;
      cnd <= 7'h01;
      settle();
      chk("held tip pos", 32'(tp), 32'h0aa);
      chk("held indication", 32'(mf), 32'h0);
      run <= 1;
      settle();
      chk("resumed tip pos", 32'(tp), 32'h0f0);
      chk("resumed indication", 32'(mf), 32'h1ff);
      fall <= 1;
      setall(8'h18);
      settle();
      chk("falling inverted tip", 32'(tp), 32'h10f);
      // Dual NRZ except channel 3
      fall <= 0;
      mode <= 2'h1;
      setall(8'h01);
      wr(8'h0c, 32'h0, rs);
      pv <= 9'h0cc;
      nv <= 9'h0aa;
      settle();
      rdt(`TSI_LINE_OFF, rd, rs);
      chk("dual oe", 32'(rd[24:16]), 32'h008);
      chk("dual indication", 32'(rd[8:0]), 32'h008);
      chk("dual tip pos", 32'(tp), 32'h04c);
      chk("dual tip neg", 32'(tn), 32'h022);
      // Dual RZ, then inverted levels
      mode <= 2'h2;
      setall(8'h02);
      settle();
      chk("rz tip pos", 32'(tp), 32'h044);
      chk("rz tip neg", 32'(tn), 32'h022);
      chk("rz oe", 32'(oe), 32'h1ff);
      chk("rz indication", 32'(mf), 32'h1ff);
      setall(8'h0a);
      settle();
      chk("rz inv tip pos", 32'(tp), 32'h022);
      chk("rz inv tip neg", 32'(tn), 32'h044);
      // Every indication select against every single source
      mode <= 2'h0;
      pv <= 9'h0;
      for (int k = 0; k < 8; k++) begin
         setall({3'(k), 5'h0});
         for (int j = 0; j < 8; j++) begin
            cnd <= (j < 7) ? 7'(1 << j) : 7'h0;
            settle();
            chk("indication", 32'(mf), {23'h0, {9{sel_exp(k, cnd)}}});
         end
      end
      // Interrupt raise, clear, mask
      setall(8'h20);
      cnd <= 7'h0;
      settle();
      wr(`TSI_CLEAR_OFF, 32'h1ff, rs);
      wr(`TSI_ENABLE_OFF, 32'h001, rs);
      cnd <= 7'h02;
      settle();
      chk("irq raised", 32'(irq), 32'h1);
      rdt(`TSI_STATUS_OFF, rd, rs);
      chk("status set", rd, 32'h1ff);
      wr(`TSI_CLEAR_OFF, 32'h1ff, rs);
      settle();
      chk("irq cleared", 32'(irq), 32'h0);
      wr(`TSI_ENABLE_OFF, 32'h0, rs);
      cnd <= 7'h0;
      settle();
      cnd <= 7'h02;
      settle();
      chk("irq masked", 32'(irq), 32'h0);
      rdt(`TSI_STATUS_OFF, rd, rs);
      chk("status masked", rd, 32'h1ff);
      wr(`TSI_ENABLE_OFF, 32'h100, rs);
      settle();
      chk("irq unmasked", 32'(irq), 32'h1);
      rdt(`TSI_ENABLE_OFF, rd, rs);
      chk("enable readback", rd, 32'h100);
      end_sim();
   end
endmodule
